// *** core/cos_top.sv ***
// CAN status lamps, bootup request and communication-loss supervision.
// Assumes a synchronous CAN controller beside it reporting its state,
// events and frame strobes, and an Avalon-MM master for the registers.
//
// Overview of operation
// [RL1] Run lamp stays dark while the CAN controller is off.
// [RL2] Run lamp has distinct patterns for stopped, pre-op and operational.
// [RL3] Error lamp stays dark while no error is reported.
// [RL4] Error lamp lights steadily while the controller is bus-off.
// [RL5] Controller error condition gets its own error lamp pattern.
// [RL6] Guard or heartbeat events get a different error lamp pattern.
// [RL7] Single flash: 200 ms on, 1 s off, repeating.
// [RL8] Double flash: on 200, off 200, on 200, off 1 s.
// [RL9] Blink at 2.5 Hz: 200 ms on, 200 ms off.
// [RL10] Node identifier lies in 1 to 127 and is unique.
// [RL11] All nodes use the same bit rate.
// [RL12] After bus init, send bootup frame 700h plus node id, data 00h.
// [RL13] Arm loss watchdog only after master wrote a command or target.
// [RL14] Default reaction to loss: resettable fault and freewheel stop.
// [RL15] Loss reaction selectable among faulting and non-faulting choices.
// [RL16] Raising the loss fault sends an emergency message.
// [RL17] Loss fault cause is kept in a readable error-code register.
// [RL18] Indicator views always match the physical lamps.
// [RL19] Run: single stopped, blink preop, on oper; error: single, double.
// [RL20] Error code 0..5 holds the last link fault until it clears.
// [RL21] PDO receive and transmit counters wrap to zero after 65535.
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "cos_map.svh"

module cos_top #(
  parameter int unsigned FLASH_ON_CYC  = `COS_FLASH_ON_CYC,
  parameter int unsigned FLASH_OFF_CYC = `COS_FLASH_OFF_CYC
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Avalon-MM register port.
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // CAN controller state and events.
  input  wire logic        i_can_off,
  input  wire logic        i_bus_off,
  input  wire logic        i_bus_init_done,
  input  wire logic [1:0]  i_nmt_state,
  input  wire logic        i_ctrl_err,
  input  wire logic        i_guard_evt,
  input  wire logic        i_hbeat_evt,
  input  wire logic        i_overrun_evt,
  input  wire logic        i_nmt_fault_evt,
  input  wire logic        i_link_ok,
  input  wire logic        i_cmd_written,
  input  wire logic        i_comm_loss,
  input  wire logic        i_rx_pdo,
  input  wire logic        i_tx_pdo,
  input  wire logic        i_tx_ack,
  // Lamps and their indicator views.
  output logic             o_run_lamp,
  output logic             o_err_lamp,
  output logic             o_run_state_indicator_view,
  output logic             o_error_indicator_view,
  // Bootup and emergency requests to the CAN controller.
  output logic             o_boot_req,
  output logic      [10:0] o_boot_id,
  output logic      [7:0]  o_boot_data,
  output logic             o_emcy_req,
  // Drive reaction.
  output logic             o_drive_fault,
  output logic      [2:0]  o_stop_mode
);

  ////////////////////////////////////////////////////////////////////////
  // Reset synchroniser.
  logic rst_s1_r;
  logic rst_n_r;

  // Release the reset through two flip-flops.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pattern timebase: one 200 ms tick and two slot phases.
  logic [31:0] tick_cnt_r;
  logic        tick;
  logic [3:0]  phase_r;
  logic [2:0]  sph_r;

  assign tick = (tick_cnt_r == FLASH_ON_CYC - 1);

  // Count 200 ms periods.
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tick_cnt_r <= 32'h0;
    end else if (tick) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // Slot phases: eight slots for most patterns, six for the single flash.
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      phase_r <= 4'h0;
      sph_r   <= 3'h0;
    end else if (tick) begin
      phase_r <= (phase_r == 4'h7) ? 4'h0 : phase_r + 4'h1;
      sph_r   <= (sph_r == 3'h5) ? 3'h0 : sph_r + 3'h1; // RL7
    end
  end

  // Lamp level for a pattern at the current slot phases.
  function automatic logic pat_level(input cos_pkg::cos_pat_e p,
                                     input logic [3:0] ph,
                                     input logic [2:0] sph);
    case (p)
      cos_pkg::COS_PAT_OFF:    return 1'b0;
      // Slot 0 on, then five slots (1 s) off; period is six slots.
      cos_pkg::COS_PAT_SINGLE: return (sph == 3'h0); // RL7
      // Slots 0 and 2 on, slots 3..7 (1 s) off.
      cos_pkg::COS_PAT_DOUBLE: return (ph == 4'h0) || (ph == 4'h2); // RL8
      cos_pkg::COS_PAT_BLINK:  return ~ph[0]; // RL9
      cos_pkg::COS_PAT_ON:     return 1'b1;
      default:                 return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pattern selection.
  cos_pkg::cos_pat_e run_pat;
  cos_pkg::cos_pat_e err_pat;

  // Run lamp pattern from controller and NMT state.
  always_comb begin
    run_pat = cos_pkg::COS_PAT_OFF;
    if (i_can_off) begin
      run_pat = cos_pkg::COS_PAT_OFF; // RL1
    end else begin
      case (cos_pkg::cos_nmt_e'(i_nmt_state))
        cos_pkg::COS_NMT_STOPPED: run_pat = cos_pkg::COS_PAT_SINGLE; // RL19
        cos_pkg::COS_NMT_PREOP:   run_pat = cos_pkg::COS_PAT_BLINK; // RL2
        cos_pkg::COS_NMT_OPER:    run_pat = cos_pkg::COS_PAT_ON; // RL2
        default:                  run_pat = cos_pkg::COS_PAT_OFF;
      endcase
    end
  end

  // Error lamp pattern; bus-off wins, then guard, then controller error.
  logic guard_seen_r;

  always_comb begin
    err_pat = cos_pkg::COS_PAT_OFF; // RL3
    if (i_bus_off) begin
      err_pat = cos_pkg::COS_PAT_ON; // RL4
    end else if (guard_seen_r) begin
      err_pat = cos_pkg::COS_PAT_DOUBLE; // RL6
    end else if (i_ctrl_err) begin
      err_pat = cos_pkg::COS_PAT_SINGLE; // RL5
    end
  end

  // Guard or heartbeat indication holds until the link is healthy again.
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      guard_seen_r <= 1'b0;
    end else if (i_guard_evt || i_hbeat_evt) begin
      guard_seen_r <= 1'b1; // RL6
    end else if (i_link_ok) begin
      guard_seen_r <= 1'b0;
    end
  end

  // Lamps and views share one level, so they can never disagree.
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_run_lamp                 <= 1'b0;
      o_err_lamp                 <= 1'b0;
      o_run_state_indicator_view <= 1'b0;
      o_error_indicator_view     <= 1'b0;
    end else begin
      o_run_lamp <= pat_level(run_pat, phase_r, sph_r);
      o_err_lamp <= pat_level(err_pat, phase_r, sph_r);
      o_run_state_indicator_view <= pat_level(run_pat, phase_r, sph_r); // RL18
      o_error_indicator_view <= pat_level(err_pat, phase_r, sph_r); // RL18
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [2:0]  react_r;
  logic [6:0]  node_r;
  logic [2:0]  err_code_r;
  logic [15:0] rx_cnt_r;
  logic [15:0] tx_cnt_r;
  logic        wr_ctrl;
  logic        fault_clr;
  logic        armed_r;

  assign wr_ctrl   = i_avs_write && !o_avs_waitrequest &&
                     (i_avs_address == `COS_REG_CTRL);
  assign fault_clr = wr_ctrl && i_avs_writedata[`COS_CTRL_FCLR_BIT];

  // Writes land at the answering edge only; a node id of zero is refused.
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      react_r <= `COS_CTRL_REACT_RST; // RL14
      node_r  <= `COS_NODE_RST;
    end else if (i_avs_write && !o_avs_waitrequest) begin
      if (i_avs_address == `COS_REG_CTRL) begin
        react_r <= i_avs_writedata[`COS_CTRL_REACT_LSB +: 3]; // RL15
      end
      if ((i_avs_address == `COS_REG_NODE) &&
          (i_avs_writedata[6:0] != 7'h00)) begin
        node_r <= i_avs_writedata[6:0]; // RL10
      end
    end
  end

  // Readback; answers one cycle after the request starts, zero when unmapped.
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_avs_readdata <= 32'h0;
    end else if (i_avs_read) begin
      case (i_avs_address)
        `COS_REG_CTRL:    o_avs_readdata <= {29'h0, react_r};
        `COS_REG_STATUS:  o_avs_readdata <= {24'h0, o_boot_req,
                                             o_emcy_req, armed_r,
                                             o_drive_fault, guard_seen_r,
                                             i_bus_off, o_err_lamp,
                                             o_run_lamp};
        `COS_REG_ERRCODE: o_avs_readdata <= {29'h0, err_code_r}; // RL17
        `COS_REG_PDOCNT:  o_avs_readdata <= {tx_cnt_r, rx_cnt_r};
        `COS_REG_NODE:    o_avs_readdata <= {25'h0, node_r};
        default:          o_avs_readdata <= 32'h0;
      endcase
    end
  end

  // Wait one cycle so read data is registered: waitrequest low next cycle.
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) &&
                             o_avs_waitrequest);
    end
  end

  // PDO counters wrap naturally at 16 bits.
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rx_cnt_r <= 16'h0;
      tx_cnt_r <= 16'h0;
    end else begin
      if (i_rx_pdo) rx_cnt_r <= rx_cnt_r + 16'h1; // RL21
      if (i_tx_pdo) tx_cnt_r <= tx_cnt_r + 16'h1; // RL21
    end
  end

  // Error code: latest fault, held until the link is healthy again.
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      err_code_r <= `COS_ERR_NONE;
    end else if (i_bus_off) begin
      err_code_r <= `COS_ERR_BUSOFF; // RL20
    end else if (i_guard_evt) begin
      err_code_r <= `COS_ERR_GUARD;
    end else if (i_overrun_evt) begin
      err_code_r <= `COS_ERR_OVERRUN;
    end else if (i_hbeat_evt) begin
      err_code_r <= `COS_ERR_HBEAT;
    end else if (i_nmt_fault_evt) begin
      err_code_r <= `COS_ERR_NMT;
    end else if (i_link_ok) begin
      err_code_r <= `COS_ERR_NONE; // RL20
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bootup sender.
  cos_pkg::cos_boot_e boot_st_r;

  // Request the bootup frame once after bus initialization.
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      boot_st_r   <= cos_pkg::COS_BT_IDLE;
      o_boot_req  <= 1'b0;
      o_boot_id   <= 11'h0;
      o_boot_data <= 8'h0;
    end else begin
      case (boot_st_r)
        cos_pkg::COS_BT_IDLE: begin
          if (i_bus_init_done) begin
            boot_st_r   <= cos_pkg::COS_BT_REQ;
            o_boot_req  <= 1'b1;
            o_boot_id   <= `COS_BOOT_BASE_ID + {4'h0, node_r}; // RL12
            o_boot_data <= `COS_BOOT_DATA; // RL12
          end
        end
        cos_pkg::COS_BT_REQ: begin
          if (i_tx_ack) begin
            boot_st_r  <= cos_pkg::COS_BT_DONE;
            o_boot_req <= 1'b0;
          end
        end
        cos_pkg::COS_BT_DONE: begin
          if (!i_bus_init_done) boot_st_r <= cos_pkg::COS_BT_IDLE;
        end
        default: boot_st_r <= cos_pkg::COS_BT_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Communication-loss supervision.
  logic faulting;

  assign faulting = (react_r <= 3'(cos_pkg::COS_RX_DCINJ));

  // Arm once the master wrote a command or target since power-up.
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      armed_r <= 1'b0;
    end else if (i_cmd_written) begin
      armed_r <= 1'b1; // RL13
    end
  end

  // Fault latch: a new loss beats a clear in the same cycle.
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_drive_fault <= 1'b0;
      o_emcy_req    <= 1'b0;
      o_stop_mode   <= 3'h0;
    end else begin
      o_emcy_req <= 1'b0;
      if (armed_r && i_comm_loss &&
          react_r != 3'(cos_pkg::COS_RX_IGNORE)) begin
        o_stop_mode <= react_r; // RL15
        if (faulting && !o_drive_fault) begin
          o_drive_fault <= 1'b1; // RL14
          o_emcy_req    <= 1'b1; // RL16
        end
      end else if (fault_clr) begin
        o_drive_fault <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  a_busoff_lamp: assert property (@(posedge i_clk) // RL4
    disable iff (!rst_n_r) i_bus_off |=> o_err_lamp)
    else $error("error lamp dark during bus-off");
  a_can_off_dark: assert property (@(posedge i_clk) // RL1
    disable iff (!rst_n_r) i_can_off |=> !o_run_lamp)
    else $error("run lamp lit while controller off");
  a_views_match: assert property (@(posedge i_clk) // RL18
    disable iff (!rst_n_r) o_run_lamp == o_run_state_indicator_view &&
    o_err_lamp == o_error_indicator_view)
    else $error("indicator view differs from lamp");
  a_no_err_dark: assert property (@(posedge i_clk) // RL3
    disable iff (!rst_n_r) (!i_bus_off && !guard_seen_r && !i_ctrl_err) |=>
    !o_err_lamp)
    else $error("error lamp lit with no error");
  a_emcy_on_fault: assert property (@(posedge i_clk) // RL16
    disable iff (!rst_n_r) $rose(o_drive_fault) |-> o_emcy_req)
    else $error("fault raised without emergency");
  a_arm_before: assert property (@(posedge i_clk) // RL13
    disable iff (!rst_n_r) $rose(o_drive_fault) |-> $past(armed_r))
    else $error("fault raised while unarmed");
  a_boot_frame: assert property (@(posedge i_clk) // RL12
    disable iff (!rst_n_r) o_boot_req |->
    o_boot_id == `COS_BOOT_BASE_ID + {4'h0, node_r} && o_boot_data == 8'h00)
    else $error("bootup frame wrong");
  a_rx_wrap: assert property (@(posedge i_clk) // RL21
    disable iff (!rst_n_r) (i_rx_pdo && &rx_cnt_r) |=> rx_cnt_r == 16'h0)
    else $error("receive counter did not wrap");
  a_oper_on: assert property (@(posedge i_clk) // RL2
    disable iff (!rst_n_r)
    (!i_can_off && i_nmt_state == 2'(cos_pkg::COS_NMT_OPER)) |=> o_run_lamp)
    else $error("run lamp not steady in operational");

  c_boot: cover property (@(posedge i_clk) disable iff (!rst_n_r)
    o_boot_req && i_tx_ack);
  c_fault: cover property (@(posedge i_clk) disable iff (!rst_n_r)
    $rose(o_drive_fault));
  c_guard: cover property (@(posedge i_clk) disable iff (!rst_n_r)
    $rose(guard_seen_r));

endmodule

// *** core/cos_map.svh ***
// Offsets, field positions, reset values and timing counts for the
// CAN status and supervision block.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
`ifndef COS_MAP_SVH
`define COS_MAP_SVH

// Clock and lamp timing.
`define COS_CLK_MHZ        100
`define COS_FLASH_ON_MS    200
`define COS_FLASH_OFF_MS   1000
`define COS_MS_CYC         (`COS_CLK_MHZ * 1000)
`define COS_FLASH_ON_CYC   (`COS_FLASH_ON_MS * `COS_MS_CYC)
`define COS_FLASH_OFF_CYC  (`COS_FLASH_OFF_MS * `COS_MS_CYC)

// Register word offsets (byte address = 4 * index).
`define COS_REG_CTRL       4'h0
`define COS_REG_STATUS     4'h1
`define COS_REG_ERRCODE    4'h2
`define COS_REG_PDOCNT     4'h3
`define COS_REG_NODE       4'h4

// Control field positions.
`define COS_CTRL_REACT_LSB 0
`define COS_CTRL_BOOT_BIT  4
`define COS_CTRL_FCLR_BIT  5
`define COS_CTRL_REACT_RST 3'h0

// Bootup frame.
`define COS_BOOT_BASE_ID   11'h700
`define COS_BOOT_DATA      8'h00
`define COS_NODE_RST       7'h01

// Error codes held in the error-code register.
`define COS_ERR_NONE       3'h0
`define COS_ERR_BUSOFF     3'h1
`define COS_ERR_GUARD      3'h2
`define COS_ERR_OVERRUN    3'h3
`define COS_ERR_HBEAT      3'h4
`define COS_ERR_NMT        3'h5

`endif

// *** core/cos_pkg.sv ***
// Types for the CAN status and supervision block.
// Assumes the constants of cos_map.svh.
package cos_pkg;

  // Network management states of the node.
  typedef enum logic [1:0] {
    COS_NMT_BOOT,
    COS_NMT_STOPPED,
    COS_NMT_PREOP,
    COS_NMT_OPER
  } cos_nmt_e;

  // Lamp patterns.
  typedef enum logic [2:0] {
    COS_PAT_OFF,
    COS_PAT_SINGLE,
    COS_PAT_DOUBLE,
    COS_PAT_BLINK,
    COS_PAT_ON
  } cos_pat_e;

  // Reaction to loss of communication.
  typedef enum logic [2:0] {
    COS_RX_FREEWHEEL,
    COS_RX_RAMP,
    COS_RX_FAST,
    COS_RX_DCINJ,
    COS_RX_IGNORE,
    COS_RX_STOP,
    COS_RX_MAINTAIN,
    COS_RX_FALLBACK
  } cos_react_e;

  // Bootup sender states.
  typedef enum logic [1:0] {
    COS_BT_IDLE,
    COS_BT_REQ,
    COS_BT_DONE
  } cos_boot_e;

endpackage

// *** sim/cos_can_model.sv ***
// Behavioural CAN controller beside the status block: sends the bootup
// frame after a chosen delay and counts emergency requests.
// Assumes the block's clock and its active-low reset.
`timescale 1ns/1ps

module cos_can_model (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Requests from the block, and the acknowledge delay set by the bench.
  input  wire logic        i_boot_req,
  input  wire logic [10:0] i_boot_id,
  input  wire logic [7:0]  i_boot_data,
  input  wire logic        i_emcy_req,
  input  wire logic [3:0]  i_ack_delay,
  // Acknowledge and record of what went out.
  output logic             o_tx_ack,
  output logic      [15:0] o_frames,
  output logic      [15:0] o_emcy_cnt,
  output logic      [10:0] o_last_id,
  output logic      [7:0]  o_last_data
);
  logic [3:0] wait_r;
  logic       sent_r;

  //////////////////////////////////////////////////////////////////////
  // A slow controller keeps the request waiting; a prompt one answers
  // in the first cycle, so both ends of the request timing are reached.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_ack    <= 1'b0;
      o_frames    <= 16'h0;
      o_last_id   <= 11'h0;
      o_last_data <= 8'h00;
      wait_r      <= 4'h0;
      sent_r      <= 1'b0;
    end else begin
      o_tx_ack <= 1'b0;
      if (!i_boot_req) begin
        sent_r <= 1'b0;
        wait_r <= 4'h0;
      end else if (!sent_r) begin
        if (wait_r == i_ack_delay) begin
          o_tx_ack    <= 1'b1;
          sent_r      <= 1'b1;
          o_last_id   <= i_boot_id;
          o_last_data <= i_boot_data;
          if (i_boot_id[6:0] != 7'h00) o_frames <= o_frames + 16'h1;
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end
    end
  end

  // Each emergency request is one message on the bus.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_emcy_cnt <= 16'h0;
    else if (i_emcy_req) o_emcy_cnt <= o_emcy_cnt + 16'h1;
  end
endmodule

// *** sim/cos_top_tb.sv ***
// Self-checking bench for the CAN status and supervision block.
// Assumes cos_top with a short lamp slot and the controller model.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  miscompares++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module cos_top_tb;
  localparam int F = 4;
  localparam int W = 24 * F;

  typedef struct {
    logic       off;
    logic       boff;
    logic       cerr;
    logic [1:0] nmt;
    int         ron;
    int         rrise;
    int         eon;
    int         erise;
  } cos_row_s;

  // Controller state beside lit cycles and rises in one 24-slot window.
  cos_row_s rows [4] = '{
    '{1'b1, 1'b0, 1'b0, 2'h3, 0, 0, 0, 0},
    '{1'b0, 1'b0, 1'b1, 2'h1, 4 * F, 4, 4 * F, 4},
    '{1'b0, 1'b1, 1'b1, 2'h2, 12 * F, 12, W, 0},
    '{1'b0, 1'b0, 1'b0, 2'h3, W, 0, 0, 0}
  };
  int codes [4] = '{2, 4, 3, 5};

  logic        i_clk, i_rst_n, i_avs_read, i_avs_write, o_avs_waitrequest;
  logic [3:0]  i_avs_address, evt, ack_dly;
  logic [31:0] i_avs_writedata, o_avs_readdata, rdat;
  logic        i_can_off, i_bus_off, i_bus_init_done, i_ctrl_err;
  logic [1:0]  i_nmt_state;
  logic        i_link_ok, i_cmd_written, i_comm_loss, i_rx_pdo, i_tx_pdo;
  logic        i_tx_ack, o_run_lamp, o_err_lamp, o_emcy_req, o_drive_fault;
  logic        o_run_state_indicator_view, o_error_indicator_view, o_boot_req;
  logic [10:0] o_boot_id, last_id;
  logic [7:0]  o_boot_data, last_data;
  logic [2:0]  o_stop_mode;
  logic [15:0] frames, emcy_n;
  int          miscompares, n_checks, ron, rr, eon, er, n;

  cos_top #(.FLASH_ON_CYC(F), .FLASH_OFF_CYC(5 * F)) dut (
    .i_clk, .i_rst_n, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_can_off,
    .i_bus_off, .i_bus_init_done, .i_nmt_state, .i_ctrl_err,
    .i_guard_evt(evt[0]), .i_hbeat_evt(evt[1]), .i_overrun_evt(evt[2]),
    .i_nmt_fault_evt(evt[3]), .i_link_ok, .i_cmd_written, .i_comm_loss,
    .i_rx_pdo, .i_tx_pdo, .i_tx_ack, .o_run_lamp, .o_err_lamp,
    .o_run_state_indicator_view, .o_error_indicator_view, .o_boot_req,
    .o_boot_id, .o_boot_data, .o_emcy_req, .o_drive_fault, .o_stop_mode);

  cos_can_model u_can (
    .i_clk, .i_rst_n, .i_boot_req(o_boot_req), .i_boot_id(o_boot_id),
    .i_boot_data(o_boot_data), .i_emcy_req(o_emcy_req),
    .i_ack_delay(ack_dly), .o_tx_ack(i_tx_ack), .o_frames(frames),
    .o_emcy_cnt(emcy_n), .o_last_id(last_id), .o_last_data(last_data));

  //////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz.
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One bus cycle, held until waitrequest is sampled low.
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int k;
    @(posedge i_clk);
    i_avs_address   <= a;
    i_avs_read      <= !w;
    i_avs_write     <= w;
    i_avs_writedata <= d;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) `CHK("bus answer", 1'b0, o_avs_waitrequest)
    q = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  // Counts lit cycles and rises over whole periods, so phase is moot.
  task measure();
    logic pr;
    logic pe;
    int   bad;
    ron = 0;
    rr  = 0;
    eon = 0;
    er  = 0;
    bad = 0;
    repeat (30) @(posedge i_clk);
    pr = o_run_lamp;
    pe = o_err_lamp;
    repeat (W) begin
      @(posedge i_clk);
      if (o_run_lamp === 1'b1) ron++;
      if (o_run_lamp === 1'b1 && pr === 1'b0) rr++;
      if (o_err_lamp === 1'b1) eon++;
      if (o_err_lamp === 1'b1 && pe === 1'b0) er++;
      if (o_run_state_indicator_view !== o_run_lamp) bad++;
      if (o_error_indicator_view !== o_err_lamp) bad++;
      pr = o_run_lamp;
      pe = o_err_lamp;
    end
    `CHK("indicator views", 0, bad)
  endtask

  // Hang guard, well beyond the expected length of the run.
  initial begin
    repeat (90000) @(posedge i_clk);
    miscompares++;
    $display("watchdog expired");
    print_verdict();
  end

  //////////////////////////////////////////////////////////////////////
  // Main sequence: reset, lamp table, then the hand-written cases.
  initial begin
    {i_avs_address, i_avs_read, i_avs_write, i_avs_writedata} = '0;
    {i_can_off, i_bus_off, i_bus_init_done, i_ctrl_err, i_nmt_state} = '0;
    {evt, i_link_ok, i_cmd_written, i_comm_loss, i_rx_pdo, i_tx_pdo} = '0;
    ack_dly = 4'h6;
    miscompares = 0;
    n_checks = 0;
    i_rst_n = 1'b0;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    bus(1'b1, 4'h9, 32'hffff_ffff, rdat);
    bus(1'b0, 4'h9, 32'h0, rdat);
    `CHK("unmapped read", 32'h0, rdat)
    bus(1'b0, 4'h0, 32'h0, rdat);
    `CHK("reaction after reset", 32'h0, rdat)
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk);
      i_can_off   <= rows[i].off;
      i_bus_off   <= rows[i].boff;
      i_ctrl_err  <= rows[i].cerr;
      i_nmt_state <= rows[i].nmt;
      measure();
      `CHK("run lit", rows[i].ron, ron)
      `CHK("run rises", rows[i].rrise, rr)
      `CHK("err lit", rows[i].eon, eon)
      `CHK("err rises", rows[i].erise, er)
    end
    $display("test lamp table done");
    bus(1'b0, 4'h2, 32'h0, rdat);
    `CHK("bus-off code held", 32'h1, rdat)
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk) i_link_ok <= 1'b1;
      @(posedge i_clk) i_link_ok <= 1'b0;
      bus(1'b0, 4'h2, 32'h0, rdat);
      `CHK("code cleared", 32'h0, rdat)
      @(posedge i_clk) evt <= 4'h1 << k;
      @(posedge i_clk) evt <= 4'h0;
      bus(1'b0, 4'h2, 32'h0, rdat);
      `CHK("error code", codes[k], rdat)
      if (k == 0) begin
        measure();
        `CHK("double lit", 6 * F, eon)
        `CHK("double rises", 6, er)
      end
    end
    $display("test error code done");
    bus(1'b1, 4'h4, 32'h7f, rdat);
    bus(1'b1, 4'h4, 32'h0, rdat);
    bus(1'b0, 4'h4, 32'h0, rdat);
    `CHK("node id", 32'h7f, rdat)
    for (int j = 0; j < 2; j++) begin
      @(posedge i_clk);
      ack_dly         <= (j == 0) ? 4'h6 : 4'h0;
      i_bus_init_done <= 1'b1;
      n = 0;
      while (frames !== 16'(j + 1) && n < 100) begin
        @(posedge i_clk);
        n++;
      end
      `CHK("bootup frames", 16'(j + 1), frames)
      `CHK("bootup id", 11'h77f, last_id)
      `CHK("bootup data", 8'h00, last_data)
      repeat (2) @(posedge i_clk);
      `CHK("bootup request ended", 1'b0, o_boot_req)
      i_bus_init_done <= 1'b0;
    end
    $display("test bootup done");
    @(posedge i_clk) i_comm_loss <= 1'b1;
    repeat (10) @(posedge i_clk);
    `CHK("unarmed loss", 1'b0, o_drive_fault)
    i_comm_loss   <= 1'b0;
    i_cmd_written <= 1'b1;
    @(posedge i_clk) i_cmd_written <= 1'b0;
    for (int r = 0; r < 8; r++) begin
      bus(1'b1, 4'h0, 32'h20 | r, rdat);
      i_comm_loss <= 1'b1;
      repeat (4) @(posedge i_clk);
      `CHK("loss fault", r < 4, o_drive_fault)
      if (r != 4) `CHK("stop mode", 3'(r), o_stop_mode)
      else `CHK("stop mode kept", 3'h3, o_stop_mode)
      i_comm_loss <= 1'b0;
      bus(1'b1, 4'h0, 32'h20 | r, rdat);
      @(posedge i_clk);
      `CHK("fault cleared", 1'b0, o_drive_fault)
    end
    `CHK("emergency count", 16'h4, emcy_n)
    $display("test loss reaction done");
    @(posedge i_clk);
    i_rx_pdo <= 1'b1;
    i_tx_pdo <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_tx_pdo <= 1'b0;
    repeat (65535) @(posedge i_clk);
    i_rx_pdo <= 1'b0;
    repeat (2) @(posedge i_clk);
    bus(1'b0, 4'h3, 32'h0, rdat);
    `CHK("frame counters", {16'h2, 16'h1}, rdat)
    $display("test frame counters done");
    print_verdict();
  end
endmodule
